//--- src/dacoc_pkg.sv
// Constants and types shared by the converter output-control register block.
// Assumes one 20 MHz reference clock and a synchronous active-low reset.
package dacoc_pkg;

  // ==========================================================================
  // Serial frame layout
  // ==========================================================================
  localparam int DACOC_DATA_W = 16;
  localparam int DACOC_ADDR_W = 7;
  localparam int DACOC_CNT_W = 5;
  localparam logic [4:0] DACOC_HEAD_LAST = 5'h07;
  localparam logic [4:0] DACOC_FRAME_LAST = 5'h17;
  localparam int DACOC_RW_BIT = 7;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [6:0] DACOC_ADDR_SHUTFMT = 7'h02;
  localparam logic [6:0] DACOC_ADDR_CURTX = 7'h03;
  localparam logic [6:0] DACOC_ADDR_FAILS = 7'h04;

  // ==========================================================================
  // Reset values and writable bits
  // ==========================================================================
  localparam logic [15:0] DACOC_SHUTFMT_RST = 16'h7000;
  localparam logic [15:0] DACOC_CURTX_RST = 16'hF000;
  localparam logic [15:0] DACOC_SHUTFMT_WMASK = 16'h70FA;
  localparam logic [15:0] DACOC_CURTX_WMASK = 16'hF001;
  localparam logic [15:0] DACOC_MID_SCALE = 16'h8000;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int DACOC_DACCLK_EN = 14;
  localparam int DACOC_DATACLK_EN = 13;
  localparam int DACOC_COLLIDE_EN = 12;
  localparam int DACOC_FOUR_WIRE = 7;
  localparam int DACOC_MIX_EN = 6;
  localparam int DACOC_MIX_GAIN = 5;
  localparam int DACOC_NCO_EN = 4;
  localparam int DACOC_BUS_REV = 3;
  localparam int DACOC_TWOS = 1;
  localparam int DACOC_COARSE_LSB = 12;
  localparam int DACOC_COARSE_W = 4;
  localparam int DACOC_SW_TXEN = 0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic serialFourWire;
    logic mixerEnable;
    logic mixerGainDouble;
    logic ncoEnable;
    logic busReverse;
    logic twosComplement;
    logic [4:0] fullScaleSteps;
    logic transmitEnable;
    logic outputShutdown;
  } dacoc_ctrl_t;

  typedef struct packed {
    logic dacClkGone;
    logic dataClkGone;
    logic fifoCollision;
  } dacoc_alarm_t;

endpackage

//--- src/dacoc_sync.sv
// Three-stage pin synchroniser, one lane per input bit.
// Assumes the inputs are asynchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module dacoc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Pins in, filtered levels out
  input wire logic [W-1:0] pinRaw,
  output logic [W-1:0] pinLevel
);
  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage3_q;
  logic [W-1:0] level_q;

  genvar i;
  // A change is taken only once the second and third stages agree.
  generate
    for (i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          stage1_q[i] <= 1'b0;
          stage2_q[i] <= 1'b0;
          stage3_q[i] <= 1'b0;
          level_q[i] <= 1'b0;
        end else begin
          stage1_q[i] <= pinRaw[i];
          stage2_q[i] <= stage1_q[i];
          stage3_q[i] <= stage2_q[i];
          if (stage2_q[i] == stage3_q[i]) begin
            level_q[i] <= stage3_q[i];
          end
        end
      end
    end
  endgenerate

  assign pinLevel = level_q;
endmodule
`default_nettype wire

//--- src/dacoc_sample_path.sv
// Per-bus sample conditioning: bit reversal, number format and mid-scale mute.
// Assumes samples arrive one word per ref_clk cycle from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module dacoc_sample_path
  import dacoc_pkg::*;
#(
  parameter int W = DACOC_DATA_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Controls
  input wire logic busReverse,
  input wire logic twosComplement,
  input wire logic muteOutput,
  // Sample in and converter code out
  input wire logic [W-1:0] sampleIn,
  output logic [W-1:0] codeOut
);
  logic [W-1:0] reversed;
  logic [W-1:0] ordered;
  logic [W-1:0] offsetCode;
  logic [W-1:0] code_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_rev
      assign reversed[i] = sampleIn[W-1-i];
    end
  endgenerate

  assign ordered = busReverse ? reversed : sampleIn;
  // Flipping the sign bit turns two's complement into offset binary.
  assign offsetCode = twosComplement ? {~ordered[W-1], ordered[W-2:0]} : ordered;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      code_q <= DACOC_MID_SCALE;
    end else begin
      code_q <= muteOutput ? DACOC_MID_SCALE : offsetCode;
    end
  end

  assign codeOut = code_q;
endmodule
`default_nettype wire

//--- src/dacoc_regs.sv
// Output-control registers of a quad converter front end, reached over the
// serial programming port, with pattern-checker results and output shutdown.
// Assumes serial pins are asynchronous and sampled by ref_clk (20 MHz), so the
// serial clock must run well below a quarter of that rate. Sample buses, clock
// monitor and FIFO alarms come from logic on ref_clk.
//
// Summary of operation
// - Conversion-clock loss switches outputs off when its shutdown enable is set.
// - Input data clock loss switches outputs off when its enable is set.
// - FIFO pointer collision switches outputs off when its enable is set.
// - Port-width bit selects four-wire serial port; cleared means three-wire.
// - Mixer block is enabled only while the mixer enable bit is set.
// - Mixer gain bit adds a factor of two at the mixer output.
// - Oscillator enabled only by its bit; coarse mixing works without it.
// - Bus-reversal bit swaps input bit order, MSB line carries LSB.
// - Format bit set means two's complement input, cleared means offset binary.
// - Four-bit coarse field scales full-scale current as value plus one; resets ones.
// - Internal transmit enable is software bit OR transmit enable pin.
// - Pattern test sets result bits for positions failing on either bus.
// - Result bit n covers bit n of both sample buses.
// - Result register has no reset value; any write clears it.
// - Shutdown register resets to 0x7000, current register to 0xF000.
// - While combined shutdown alarm is high, outputs carry mid-scale 0x8000.
// - Pattern checker runs only while its enable bit is set.
`timescale 1ns/10ps
`default_nettype none
module dacoc_regs
  import dacoc_pkg::*;
#(
  parameter int W = DACOC_DATA_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Serial programming port
  input wire logic serialClk,
  input wire logic serialEnable_n,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  output logic serial_port_four_wire_out,
  output logic serial_port_four_wire_oe,
  // Transmit enable pin
  input wire logic transmit_enable_pin,
  // Clock monitor and FIFO alarms
  input wire dacoc_alarm_t alarmIn,
  // Pattern checker
  input wire logic patternCheckEnable,
  input wire logic [W-1:0] expectFirst,
  input wire logic [W-1:0] expectSecond,
  // Sample buses
  input wire logic [W-1:0] first_pair_bus,
  input wire logic [W-1:0] second_pair_bus,
  // Converter codes and control
  output logic [W-1:0] firstCode,
  output logic [W-1:0] secondCode,
  output logic alarmOutputGone,
  output dacoc_ctrl_t ctrl
);

  // ==========================================================================
  // Pin synchronisation
  // ==========================================================================
  logic [2:0] pinLevel;
  logic [2:0] pinRaw;
  logic sclkLevel;
  logic enableLevel_n;
  logic dinLevel;
  logic txPinLevel;
  logic txPinLevel_q;

  assign pinRaw = {serialClk, serialEnable_n, serialDataIn};

  dacoc_sync #(
    .W(3)
  ) u_serial_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinRaw(pinRaw),
    .pinLevel(pinLevel)
  );

  assign sclkLevel = pinLevel[2];
  assign enableLevel_n = pinLevel[1];
  assign dinLevel = pinLevel[0];

  // The transmit pin rides a single-lane copy of the same filter.
  dacoc_sync #(
    .W(1)
  ) u_txen_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinRaw(transmit_enable_pin),
    .pinLevel(txPinLevel)
  );

  // ==========================================================================
  // Serial clock edges
  // ==========================================================================
  logic sclkPrev_q;
  logic sclkRise;
  logic sclkFall;
  logic frameActive;

  assign sclkRise = sclkLevel && !sclkPrev_q;
  assign sclkFall = !sclkLevel && sclkPrev_q;
  assign frameActive = !enableLevel_n;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sclkPrev_q <= 1'b0;
      txPinLevel_q <= 1'b0;
    end else begin
      sclkPrev_q <= sclkLevel;
      txPinLevel_q <= txPinLevel;
    end
  end

  // ==========================================================================
  // Serial frame sequencer
  // ==========================================================================
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_HEAD = 2'b01,
    SP_DATA = 2'b10,
    SP_DONE = 2'b11
  } dacoc_sp_state_t;

  dacoc_sp_state_t state_q;
  dacoc_sp_state_t state_d;
  logic [DACOC_CNT_W-1:0] bitCount_q;
  logic [DACOC_CNT_W-1:0] bitCount_d;
  logic [W-1:0] shiftIn_q;
  logic [W-1:0] shiftIn_d;
  logic [DACOC_ADDR_W-1:0] addr_q;
  logic isRead_q;
  logic headDone;
  logic frameDone;
  logic writeStrobe;

  assign headDone = (state_q == SP_HEAD) && sclkRise && (bitCount_q == DACOC_HEAD_LAST);
  assign frameDone = (state_q == SP_DATA) && sclkRise && (bitCount_q == DACOC_FRAME_LAST);
  assign writeStrobe = frameDone && !isRead_q;
  assign shiftIn_d = {shiftIn_q[W-2:0], dinLevel};

  always_comb begin
    state_d = state_q;
    bitCount_d = bitCount_q;
    unique case (state_q)
      SP_IDLE: begin
        bitCount_d = '0;
        if (frameActive) begin
          state_d = SP_HEAD;
        end
      end
      SP_HEAD: begin
        if (sclkRise) begin
          bitCount_d = bitCount_q + 5'h01;
        end
        if (headDone) begin
          state_d = SP_DATA;
        end
      end
      SP_DATA: begin
        if (sclkRise) begin
          bitCount_d = bitCount_q + 5'h01;
        end
        if (frameDone) begin
          state_d = SP_DONE;
        end
      end
      SP_DONE: begin
        bitCount_d = '0;
      end
    endcase
    // Raising the enable aborts any frame; a partial write is dropped.
    if (!frameActive) begin
      state_d = SP_IDLE;
      bitCount_d = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= SP_IDLE;
      bitCount_q <= '0;
      shiftIn_q <= '0;
      addr_q <= '0;
      isRead_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bitCount_q <= bitCount_d;
      if (sclkRise && frameActive) begin
        shiftIn_q <= shiftIn_d;
      end
      if (headDone) begin
        isRead_q <= shiftIn_d[DACOC_RW_BIT];
        addr_q <= shiftIn_d[DACOC_ADDR_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Register decode
  // ==========================================================================
  logic [W-1:0] shutFmt_q;
  logic [W-1:0] curTx_q;
  logic [W-1:0] failures_q;
  logic hitShutFmt;
  logic hitCurTx;
  logic hitFails;
  logic [W-1:0] readData;

  assign hitShutFmt = (addr_q == DACOC_ADDR_SHUTFMT);
  assign hitCurTx = (addr_q == DACOC_ADDR_CURTX);
  assign hitFails = (addr_q == DACOC_ADDR_FAILS);

  // Unmapped offsets read as zero.
  assign readData = hitShutFmt ? shutFmt_q :
                    hitCurTx ? curTx_q :
                    hitFails ? failures_q : '0;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      shutFmt_q <= DACOC_SHUTFMT_RST;
      curTx_q <= DACOC_CURTX_RST;
    end else if (writeStrobe) begin
      if (hitShutFmt) begin
        shutFmt_q <= shiftIn_d & DACOC_SHUTFMT_WMASK;
      end
      if (hitCurTx) begin
        curTx_q <= shiftIn_d & DACOC_CURTX_WMASK;
      end
    end
  end

  // ==========================================================================
  // Pattern checker results
  // ==========================================================================
  logic [W-1:0] failBits;
  logic clearFails;

  // Bit n compares bit n of both buses against the expected patterns.
  assign failBits = patternCheckEnable ?
                    ((first_pair_bus ^ expectFirst) | (second_pair_bus ^ expectSecond)) :
                    '0;
  assign clearFails = writeStrobe && hitFails;

  // Deliberately no reset: the result is undefined until cleared by a write.
  // A failure in the clearing cycle survives the clear.
  always_ff @(posedge ref_clk) begin
    failures_q <= (clearFails ? '0 : failures_q) | failBits;
  end

  // ==========================================================================
  // Read shifter and pin drivers
  // ==========================================================================
  logic [W-1:0] shiftOut_q;
  logic outBit_q;
  logic loadRead_q;
  logic driving;
  logic fourWire;

  assign fourWire = shutFmt_q[DACOC_FOUR_WIRE];
  assign driving = frameActive && isRead_q && (state_q == SP_DATA);

  // The address register only settles on the header's last edge, so the read
  // word is picked up one cycle later, long before the first falling clock.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      loadRead_q <= 1'b0;
      shiftOut_q <= '0;
      outBit_q <= 1'b0;
    end else begin
      loadRead_q <= headDone;
      if (loadRead_q) begin
        shiftOut_q <= readData;
      end else if (driving && sclkFall) begin
        outBit_q <= shiftOut_q[W-1];
        shiftOut_q <= {shiftOut_q[W-2:0], 1'b0};
      end
    end
  end

  // Three-wire reads turn the data pin around; four-wire reads use the output pin.
  assign serialDataOut = outBit_q;
  assign serialDataOe = driving && !fourWire;
  assign serial_port_four_wire_out = outBit_q;
  assign serial_port_four_wire_oe = driving && fourWire;

  // ==========================================================================
  // Output shutdown and transmit enable
  // ==========================================================================
  logic shutdownNow;
  logic txEnable;
  logic muteOutput;
  logic alarm_q;
  dacoc_ctrl_t ctrl_q;

  assign shutdownNow = (alarmIn.dacClkGone && shutFmt_q[DACOC_DACCLK_EN]) ||
                       (alarmIn.dataClkGone && shutFmt_q[DACOC_DATACLK_EN]) ||
                       (alarmIn.fifoCollision && shutFmt_q[DACOC_COLLIDE_EN]);
  assign txEnable = curTx_q[DACOC_SW_TXEN] || txPinLevel_q;
  // The pattern test also silences the outputs whatever the transmit enable.
  assign muteOutput = alarm_q || !txEnable || patternCheckEnable;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      alarm_q <= 1'b0;
      // The step count mirrors the all-ones coarse field from the first cycle.
      ctrl_q <= '{fullScaleSteps: 5'h10, default: '0};
    end else begin
      alarm_q <= shutdownNow;
      ctrl_q.serialFourWire <= fourWire;
      ctrl_q.mixerEnable <= shutFmt_q[DACOC_MIX_EN];
      ctrl_q.mixerGainDouble <= shutFmt_q[DACOC_MIX_GAIN];
      ctrl_q.ncoEnable <= shutFmt_q[DACOC_NCO_EN];
      ctrl_q.busReverse <= shutFmt_q[DACOC_BUS_REV];
      ctrl_q.twosComplement <= shutFmt_q[DACOC_TWOS];
      ctrl_q.fullScaleSteps <=
        {1'b0, curTx_q[DACOC_COARSE_LSB +: DACOC_COARSE_W]} + 5'h01;
      ctrl_q.transmitEnable <= txEnable;
      ctrl_q.outputShutdown <= shutdownNow;
    end
  end

  assign alarmOutputGone = alarm_q;
  assign ctrl = ctrl_q;

  // ==========================================================================
  // Sample paths
  // ==========================================================================
  dacoc_sample_path #(
    .W(W)
  ) u_first_path (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .busReverse(shutFmt_q[DACOC_BUS_REV]),
    .twosComplement(shutFmt_q[DACOC_TWOS]),
    .muteOutput(muteOutput),
    .sampleIn(first_pair_bus),
    .codeOut(firstCode)
  );

  dacoc_sample_path #(
    .W(W)
  ) u_second_path (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .busReverse(shutFmt_q[DACOC_BUS_REV]),
    .twosComplement(shutFmt_q[DACOC_TWOS]),
    .muteOutput(muteOutput),
    .sampleIn(second_pair_bus),
    .codeOut(secondCode)
  );

endmodule
`default_nettype wire

//--- verif/dacoc_regs_chk.sv
// Concurrent checks on the ports of the output-control register block.
// Assumes it is bound to dacoc_regs and sees nothing but its ports.
`timescale 1ns/10ps
`default_nettype none
module dacoc_regs_chk
  import dacoc_pkg::*;
#(
  parameter int W = DACOC_DATA_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Serial port
  input wire logic serialEnable_n,
  input wire logic serialDataOe,
  input wire logic serial_port_four_wire_oe,
  // Pins and alarms
  input wire logic transmit_enable_pin,
  input wire dacoc_alarm_t alarmIn,
  input wire logic patternCheckEnable,
  // Sample path
  input wire logic [W-1:0] first_pair_bus,
  input wire logic [W-1:0] firstCode,
  input wire logic [W-1:0] secondCode,
  input wire logic alarmOutputGone,
  input wire dacoc_ctrl_t ctrl
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // =====
  // Sample path
  // =====
  // Reversal is left out here; the bench checks it with known words.
  sequence s_clean;
    ctrl.transmitEnable && !alarmOutputGone && !patternCheckEnable && !ctrl.busReverse;
  endsequence
  sequence s_muted;
    firstCode == DACOC_MID_SCALE && secondCode == DACOC_MID_SCALE;
  endsequence

  a_code_format: assert property (s_clean [*3] |->
    firstCode == ($past(first_pair_bus) ^ {ctrl.twosComplement, 15'h0}))
    else $error("code does not follow the sample format");
  a_shut_mute: assert property (alarmOutputGone |=> s_muted)
    else $error("shutdown did not give mid-scale codes");
  a_shut_cause: assert property (alarmOutputGone |-> |$past(alarmIn))
    else $error("shutdown raised without a source");
  a_txen_pin: assert property (transmit_enable_pin [*7] |-> ctrl.transmitEnable)
    else $error("transmit pin did not enable output");
  a_tx_off: assert property (!ctrl.transmitEnable [*2] |-> s_muted)
    else $error("output not muted with transmit disabled");
  a_steps_range: assert property (ctrl.fullScaleSteps inside {[1:16]})
    else $error("current steps out of range");

  // =====
  // Serial port
  // =====
  a_oe_mode: assert property (serialDataOe || serial_port_four_wire_oe |->
    serial_port_four_wire_oe == ctrl.serialFourWire && !(serialDataOe && serial_port_four_wire_oe))
    else $error("read data on the wrong pin");
  a_oe_idle: assert property (serialEnable_n [*7] |->
    !serialDataOe && !serial_port_four_wire_oe)
    else $error("data pin driven outside a frame");
endmodule

bind dacoc_regs dacoc_regs_chk #(.W(W)) chk (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .serialEnable_n(serialEnable_n),
  .serialDataOe(serialDataOe),
  .serial_port_four_wire_oe(serial_port_four_wire_oe),
  .transmit_enable_pin(transmit_enable_pin),
  .alarmIn(alarmIn),
  .patternCheckEnable(patternCheckEnable),
  .first_pair_bus(first_pair_bus),
  .firstCode(firstCode),
  .secondCode(secondCode),
  .alarmOutputGone(alarmOutputGone),
  .ctrl(ctrl)
);
`default_nettype wire

//--- verif/dacoc_host.sv
// Host controller model for the serial programming port.
// Assumes xfer is called just after a rising ref_clk edge.
`timescale 1ns/10ps
`default_nettype none
module dacoc_host (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  output logic serialClk,
  output logic serialEnable_n,
  output logic serialDataIn,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic serial_port_four_wire_out,
  input wire logic serial_port_four_wire_oe
);
  // The host keeps the source and combined alarm masks clear.
  localparam logic [15:0] maskWord = 16'h0000;
  logic hostBit = 1'b0;
  logic hostOe = 1'b0;
  logic lastData = 1'b0;
  logic lastOut = 1'b0;
  logic outPin;

  // A released pin toggles, so a stale bit can never pass for read data.
  assign serialDataIn = serialDataOe ? serialDataOut : (hostOe ? hostBit : ~lastData);
  assign outPin = serial_port_four_wire_oe ? serial_port_four_wire_out : ~lastOut;

  initial begin
    serialClk = 1'b0;
    serialEnable_n = 1'b1;
  end

  always @(posedge ref_clk) begin
    lastData <= serialDataIn;
    lastOut <= outPin;
  end

  // Half period of six ref_clk cycles; the clock stays low between frames.
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wd,
      input int nClk, input logic fourW, output logic [15:0] rdata);
    logic [23:0] frame;
    frame = {rd, addr, wd};
    rdata = 16'h0000;
    serialEnable_n <= 1'b0;
    for (int i = 0; i < nClk; i++) begin
      hostBit <= frame[23 - i];
      hostOe <= !(rd && i >= 8);
      repeat (6) @(posedge ref_clk);
      if (rd && i >= 8) begin
        rdata = {rdata[14:0], fourW ? outPin : serialDataIn};
      end
      serialClk <= 1'b1;
      repeat (6) @(posedge ref_clk);
      serialClk <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    serialEnable_n <= 1'b1;
    hostOe <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- verif/dacoc_regs_tb.sv
// Self-checking bench for the output-control register block.
// Assumes the host model carries every serial frame.
`timescale 1ns/10ps
`default_nettype none
module dacoc_regs_tb
  import dacoc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic transmit_enable_pin = 1'b0;
  dacoc_alarm_t alarmIn = '0;
  logic patternCheckEnable = 1'b0;
  logic [15:0] expectFirst = 16'h0000;
  logic [15:0] expectSecond = 16'h0000;
  logic [15:0] first_pair_bus = 16'h0000;
  logic [15:0] second_pair_bus = 16'h0000;
  logic serialClk, serialEnable_n, serialDataIn, serialDataOut, serialDataOe;
  logic fourOut, fourOe, alarmOutputGone;
  logic [15:0] firstCode, secondCode;
  dacoc_ctrl_t ctrl;
  logic fourW = 1'b0;
  int badCount = 0;
  int testsRun = 0;

  always #25 ref_clk = ~ref_clk;

  dacoc_regs dut (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .serialClk(serialClk), .serialEnable_n(serialEnable_n),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .serial_port_four_wire_out(fourOut),
    .serial_port_four_wire_oe(fourOe), .transmit_enable_pin(transmit_enable_pin),
    .alarmIn(alarmIn), .patternCheckEnable(patternCheckEnable),
    .expectFirst(expectFirst), .expectSecond(expectSecond),
    .first_pair_bus(first_pair_bus), .second_pair_bus(second_pair_bus),
    .firstCode(firstCode), .secondCode(secondCode),
    .alarmOutputGone(alarmOutputGone), .ctrl(ctrl)
  );

  dacoc_host host (
    .ref_clk(ref_clk), .serialClk(serialClk), .serialEnable_n(serialEnable_n),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .serial_port_four_wire_out(fourOut),
    .serial_port_four_wire_oe(fourOe)
  );

  // =====
  // Shared tasks
  // =====
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n = 24);
    logic [15:0] unused;
    host.xfer(1'b0, a, d, n, fourW, unused);
    if (a == 7'h02 && n == 24) fourW = d[7];
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host.xfer(1'b1, a, 16'h0000, 24, fourW, v);
    chk(v, exp);
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // =====
  // Scenarios
  // =====
  task automatic t_reset;
    reset_n <= 1'b0;
    cyc(10);
    chk(firstCode, 16'h8000);
    reset_n <= 1'b1;
    fourW = 1'b0;
    cyc(5);
    chk(16'(ctrl.fullScaleSteps), 16'h0010);
    rd(7'h02, 16'h7000);
    rd(7'h03, 16'hF000);
    $display("reset test done");
  endtask

  task automatic t_regs;
    wr(7'h02, 16'hFFFF);
    rd(7'h02, 16'h70FA);
    chk(16'(ctrl[12:7]), 16'h003F);
    wr(7'h02, 16'h7000);
    rd(7'h02, 16'h7000);
    chk(16'(ctrl[12:7]), 16'h0000);
    wr(7'h03, 16'hFFFF);
    rd(7'h03, 16'hF001);
    chk(16'(ctrl.transmitEnable), 16'h0001);
    wr(7'h03, 16'h0000);
    chk(16'(ctrl.fullScaleSteps), 16'h0001);
    wr(7'h03, 16'h5000);
    chk(16'(ctrl.fullScaleSteps), 16'h0006);
    wr(7'h03, 16'hF000, 20);
    rd(7'h03, 16'h5000);
    wr(7'h10, 16'hFFFF);
    rd(7'h10, 16'h0000);
    wr(7'h03, 16'hF000);
    $display("register test done");
  endtask

  task automatic t_format;
    transmit_enable_pin <= 1'b1;
    first_pair_bus <= 16'h1234;
    second_pair_bus <= 16'h00F1;
    cyc(8);
    chk(firstCode, 16'h1234);
    wr(7'h02, 16'h7002);
    chk(firstCode, 16'h9234);
    chk(secondCode, 16'h80F1);
    wr(7'h02, 16'h7008);
    chk(firstCode, 16'h2C48);
    chk(secondCode, 16'h8F00);
    transmit_enable_pin <= 1'b0;
    cyc(8);
    chk(firstCode, 16'h8000);
    wr(7'h03, 16'hF001);
    chk(firstCode, 16'h2C48);
    wr(7'h02, 16'h7000);
    $display("format test done");
  endtask

  task automatic t_shut;
    for (int i = 0; i < 3; i++) begin
      alarmIn <= 3'b100 >> i;
      cyc(4);
      chk(16'(alarmOutputGone), 16'h0001);
      chk(16'(ctrl.outputShutdown), 16'h0001);
      chk(secondCode, 16'h8000);
      wr(7'h02, 16'h7000 & ~(16'h4000 >> i));
      chk(16'(alarmOutputGone), 16'h0000);
      alarmIn <= 3'b000;
      wr(7'h02, 16'h7000);
    end
    $display("shutdown test done");
  endtask

  task automatic t_pattern;
    wr(7'h04, 16'h0000);
    rd(7'h04, 16'h0000);
    expectFirst <= 16'hAAAA;
    expectSecond <= 16'h5555;
    first_pair_bus <= 16'hAAAB;
    second_pair_bus <= 16'hD555;
    cyc(4);
    rd(7'h04, 16'h0000);
    patternCheckEnable <= 1'b1;
    cyc(4);
    patternCheckEnable <= 1'b0;
    rd(7'h04, 16'h8001);
    wr(7'h04, 16'h1234);
    rd(7'h04, 16'h0000);
    $display("pattern test done");
  endtask

  initial begin
    cyc(60000);
    badCount++;
    summarize();
  end

  initial begin
    @(posedge ref_clk);
    t_reset();
    t_regs();
    t_format();
    t_shut();
    t_pattern();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
